// ===== design/iqps_map.svh
// Register map, field positions and reset values of the sync register bank
`ifndef IQPS_MAP_SVH
`define IQPS_MAP_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define IQPS_IDX_CD_OFFSET   6'h0e
`define IQPS_IDX_CD_GAIN     6'h0f
`define IQPS_IDX_CD_PHASE    6'h11
`define IQPS_IDX_AB_SHIFT    6'h12
`define IQPS_IDX_AB_FREQ_LO  6'h14
`define IQPS_IDX_AB_FREQ_HI  6'h15
`define IQPS_IDX_IQ_AUTOSYNC 6'h1e
`define IQPS_IDX_MX_AUTOSYNC 6'h1f
`define IQPS_IDX_SYNC_CMD    6'h20

// ----------------------------------------
// Fields
// ----------------------------------------
`define IQPS_COEFF_MSB       11
`define IQPS_COEFF_FRAC      12
`define IQPS_AUTOSYNC_BIT    0
`define IQPS_CMD_QMC_BIT     0
`define IQPS_CMD_MIX_BIT     1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define IQPS_RST_WORD        16'h0000
`define IQPS_RST_COEFF       12'h000
`define IQPS_RST_FREQ        32'h0000_0000

`endif

// ===== design/iqps_nco_phase.sv
// Oscillator accumulator with phase shift forming the sine/cosine table index
`default_nettype none
`include "iqps_map.svh"

module iqps_nco_phase
  import iqps_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire iqps_freq_t freq_word,
  input  wire iqps_word_t phase_shift,
  output var  iqps_word_t lut_index
);

  iqps_freq_t acc_r;
  iqps_word_t index_nxt;

  // ----------------------------------------
  // Phase shift on upper accumulator bits
  // ----------------------------------------
  // offset onto top bits
  assign index_nxt = acc_r[31:16] + phase_shift;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      acc_r     <= `IQPS_RST_FREQ;
      lut_index <= `IQPS_RST_WORD;
    end else begin
      acc_r     <= acc_r + freq_word;
      lut_index <= index_nxt;
    end
  end

endmodule

`default_nettype wire

// ===== design/iqps_pkg.sv
// Types shared by the sync register bank and its oscillator phase stage
`default_nettype none

package iqps_pkg;
  typedef logic signed [15:0] iqps_sample_t;
  typedef logic [15:0]        iqps_word_t;
  typedef logic signed [11:0] iqps_coeff_t;
  typedef logic [31:0]        iqps_freq_t;
endpackage

`default_nettype wire

// ===== design/iqps_sync_regs.sv
// Auto-syncing phase correction and oscillator phase shift register bank
// ----------------------------------------
// ----------------------------------------
`default_nettype none
`include "iqps_map.svh"

module iqps_sync_regs
  import iqps_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire logic [7:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  output var  logic [31:0]  avs_readdata,
  output var  logic         avs_waitrequest,
  input  wire iqps_sample_t c_sample,
  input  wire iqps_sample_t d_sample,
  output var  iqps_sample_t c_corrected,
  output var  iqps_sample_t d_delayed,
  output var  iqps_word_t   cd_gain_active,
  output var  iqps_word_t   cd_offset_active,
  output var  iqps_coeff_t  cd_coeff_active,
  output var  iqps_freq_t   ab_freq_active,
  output var  iqps_word_t   ab_shift_active,
  output var  iqps_word_t   ab_lut_index
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic iqps_word_t merge16(input iqps_word_t old_v,
                                         input logic [15:0] wd,
                                         input logic [1:0] be);
    merge16 = old_v;
    if (be[0]) merge16[7:0] = wd[7:0];
    if (be[1]) merge16[15:8] = wd[15:8];
  endfunction

  function automatic iqps_sample_t sat16(input logic signed [17:0] v);
    if (v > 18'sd32767) sat16 = 16'sh7fff;
    else if (v < -18'sd32768) sat16 = 16'sh8000;
    else sat16 = v[15:0];
  endfunction

  // ----------------------------------------
  // Staging and control registers
  // ----------------------------------------
  iqps_word_t  cd_offset_stage_r;
  iqps_word_t  cd_gain_stage_r;
  iqps_coeff_t cd_phase_stage_r;
  iqps_word_t  ab_shift_stage_r;
  iqps_word_t  ab_freq_lo_stage_r;
  iqps_word_t  ab_freq_hi_stage_r;
  logic        iq_autosync_r;
  logic        mx_autosync_r;
  logic        qmc_sync_r;
  logic        mix_sync_r;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire logic [5:0]  reg_idx   = avs_address[7:2];
  wire logic        req       = avs_read | avs_write;
  wire logic        wr_take   = avs_write & ~avs_waitrequest;
  wire logic [15:0] wd        = avs_writedata[15:0];
  wire logic [1:0]  be        = avs_byteenable[1:0];
  wire logic        hit_off   = reg_idx == `IQPS_IDX_CD_OFFSET;
  wire logic        hit_gain  = reg_idx == `IQPS_IDX_CD_GAIN;
  wire logic        hit_phase = reg_idx == `IQPS_IDX_CD_PHASE;
  wire logic        hit_shift = reg_idx == `IQPS_IDX_AB_SHIFT;
  wire logic        hit_flo   = reg_idx == `IQPS_IDX_AB_FREQ_LO;
  wire logic        hit_fhi   = reg_idx == `IQPS_IDX_AB_FREQ_HI;
  wire logic        hit_iqen  = reg_idx == `IQPS_IDX_IQ_AUTOSYNC;
  wire logic        hit_mxen  = reg_idx == `IQPS_IDX_MX_AUTOSYNC;
  wire logic        hit_cmd   = reg_idx == `IQPS_IDX_SYNC_CMD;

  wire iqps_word_t  phase_rd  = {4'h0, cd_phase_stage_r};
  wire iqps_word_t  phase_wr  = merge16(phase_rd, wd, be);

  wire iqps_word_t  rd_word =
      hit_off   ? cd_offset_stage_r  :
      hit_gain  ? cd_gain_stage_r    :
      hit_phase ? phase_rd           :
      hit_shift ? ab_shift_stage_r   :
      hit_flo   ? ab_freq_lo_stage_r :
      hit_fhi   ? ab_freq_hi_stage_r :
      hit_iqen  ? {15'h0000, iq_autosync_r} :
      hit_mxen  ? {15'h0000, mx_autosync_r} :
      16'h0000;

  // Sync triggers; autosync writes need byte lane 0 or 1 written, command writes need lane 0
  wire logic wr_lane    = wr_take & (|be);
  wire logic qmc_trig   = wr_lane & hit_phase & iq_autosync_r;
  wire logic mix_trig   = wr_lane & hit_shift & mx_autosync_r;
  wire logic qmc_manual = wr_take & hit_cmd & be[0] & wd[`IQPS_CMD_QMC_BIT];
  wire logic mix_manual = wr_take & hit_cmd & be[0] & wd[`IQPS_CMD_MIX_BIT];

  // ----------------------------------------
  // Avalon handshake: one wait state
  // ----------------------------------------
  // Waitrequest drops one cycle after a request and rises again after the take
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (avs_read & avs_waitrequest) begin
        avs_readdata <= {16'h0000, rd_word};
      end
    end
  end

  // ----------------------------------------
  // Staged register writes
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cd_offset_stage_r  <= `IQPS_RST_WORD;
      cd_gain_stage_r    <= `IQPS_RST_WORD;
      cd_phase_stage_r   <= `IQPS_RST_COEFF;
      ab_shift_stage_r   <= `IQPS_RST_WORD;
      ab_freq_lo_stage_r <= `IQPS_RST_WORD;
      ab_freq_hi_stage_r <= `IQPS_RST_WORD;
      iq_autosync_r      <= 1'b0;
      mx_autosync_r      <= 1'b0;
    end else if (wr_take) begin
      if (hit_off)   cd_offset_stage_r  <= merge16(cd_offset_stage_r, wd, be);
      if (hit_gain)  cd_gain_stage_r    <= merge16(cd_gain_stage_r, wd, be);
      if (hit_phase) cd_phase_stage_r   <= phase_wr[`IQPS_COEFF_MSB:0];
      if (hit_shift) ab_shift_stage_r   <= merge16(ab_shift_stage_r, wd, be);
      if (hit_flo)   ab_freq_lo_stage_r <= merge16(ab_freq_lo_stage_r, wd, be);
      if (hit_fhi)   ab_freq_hi_stage_r <= merge16(ab_freq_hi_stage_r, wd, be);
      if (hit_iqen & be[0]) iq_autosync_r <= wd[`IQPS_AUTOSYNC_BIT];
      if (hit_mxen & be[0]) mx_autosync_r <= wd[`IQPS_AUTOSYNC_BIT];
    end
  end

  // ----------------------------------------
  // Sync transfer to active settings
  // ----------------------------------------
  // Delayed one cycle so the triggering word itself is already staged
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      qmc_sync_r <= 1'b0;
      mix_sync_r <= 1'b0;
    end else begin
      qmc_sync_r <= qmc_trig | qmc_manual;
      mix_sync_r <= mix_trig | mix_manual;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cd_gain_active   <= `IQPS_RST_WORD;
      cd_offset_active <= `IQPS_RST_WORD;
      cd_coeff_active  <= `IQPS_RST_COEFF;
      ab_freq_active   <= `IQPS_RST_FREQ;
      ab_shift_active  <= `IQPS_RST_WORD;
    end else begin
      if (qmc_sync_r) begin
        cd_gain_active   <= cd_gain_stage_r;
        cd_offset_active <= cd_offset_stage_r;
        cd_coeff_active  <= cd_phase_stage_r;
      end
      // halves joined, high word on top
      if (mix_sync_r) begin
        ab_freq_active  <= {ab_freq_hi_stage_r, ab_freq_lo_stage_r};
        ab_shift_active <= ab_shift_stage_r;
      end
    end
  end

  // ----------------------------------------
  // CD phase correction
  // ----------------------------------------
  // coefficient weight is value over 4096
  wire logic signed [27:0] d_prod  = d_sample * cd_coeff_active;
  wire logic signed [15:0] d_scale = d_prod[`IQPS_COEFF_FRAC+15:`IQPS_COEFF_FRAC];
  wire logic signed [17:0] c_sum   = 18'(c_sample) + 18'(d_scale);

  // Saturation keeps a large correction from wrapping the C sample
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      c_corrected <= 16'sh0000;
      d_delayed   <= 16'sh0000;
    end else begin
      c_corrected <= sat16(c_sum);
      d_delayed   <= d_sample;
    end
  end

  // ----------------------------------------
  // AB oscillator phase stage
  // ----------------------------------------
  iqps_nco_phase u_nco (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .freq_word   (ab_freq_active),
    .phase_shift (ab_shift_active),
    .lut_index   (ab_lut_index)
  );

endmodule

`default_nettype wire

// ===== testbench/iqps_sync_checker.sv
// Port assertions for the sync register bank
`default_nettype none
module iqps_sync_checker
  import iqps_pkg::*;
(
  input wire logic         sys_clk,
  input wire logic         reset,
  input wire logic [7:0]   avs_address,
  input wire logic         avs_read,
  input wire logic         avs_write,
  input wire logic [31:0]  avs_writedata,
  input wire logic [3:0]   avs_byteenable,
  input wire logic [31:0]  avs_readdata,
  input wire logic         avs_waitrequest,
  input wire iqps_sample_t c_sample,
  input wire iqps_sample_t d_sample,
  input wire iqps_sample_t c_corrected,
  input wire iqps_sample_t d_delayed,
  input wire iqps_word_t   cd_gain_active,
  input wire iqps_word_t   cd_offset_active,
  input wire iqps_coeff_t  cd_coeff_active,
  input wire iqps_freq_t   ab_freq_active,
  input wire iqps_word_t   ab_shift_active,
  input wire iqps_word_t   ab_lut_index
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // Assertions
  // ----------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire logic tk = avs_write && !avs_waitrequest;
  wire logic qmc_trig = tk && (avs_address[7:2] == 6'h11 || avs_address[7:2] == 6'h20);
  wire logic mix_trig = tk && (avs_address[7:2] == 6'h12 || avs_address[7:2] == 6'h20);
  sequence req_seen;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence answered;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  wait_one_a: assert property (req_seen |=> answered) else $error("no single wait state");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait low too long");
  rd_upper_a: assert property (avs_readdata[31:16] == 16'h0000) else $error("read upper bits set");
  // Active values only move on a sync
  qmc_sync_a: assert property ($changed({cd_gain_active, cd_offset_active, cd_coeff_active})
    |-> $past(qmc_trig, 2)) else $error("correction set moved without sync");
  mix_sync_a: assert property ($changed({ab_freq_active, ab_shift_active})
    |-> $past(mix_trig, 2)) else $error("mixer set moved without sync");
  pass_thru_a: assert property (!$past(reset) && $past(cd_coeff_active) == 12'h000
    |-> c_corrected == $past(c_sample)) else $error("zero coefficient altered C");
  d_delay_a: assert property (!$past(reset) |-> d_delayed == $past(d_sample)) else $error("D misaligned");
  rst_vals_a: assert property (disable iff (1'b0) reset |=> avs_waitrequest &&
    cd_coeff_active == 12'h000 && ab_shift_active == 16'h0000) else $error("reset values wrong");
endmodule
bind iqps_sync_regs iqps_sync_checker u_chk (
  .sys_clk          (sys_clk),
  .reset            (reset),
  .avs_address      (avs_address),
  .avs_read         (avs_read),
  .avs_write        (avs_write),
  .avs_writedata    (avs_writedata),
  .avs_byteenable   (avs_byteenable),
  .avs_readdata     (avs_readdata),
  .avs_waitrequest  (avs_waitrequest),
  .c_sample         (c_sample),
  .d_sample         (d_sample),
  .c_corrected      (c_corrected),
  .d_delayed        (d_delayed),
  .cd_gain_active   (cd_gain_active),
  .cd_offset_active (cd_offset_active),
  .cd_coeff_active  (cd_coeff_active),
  .ab_freq_active   (ab_freq_active),
  .ab_shift_active  (ab_shift_active),
  .ab_lut_index     (ab_lut_index)
);
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench for the sync register bank
`default_nettype none
module tb
  import iqps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         sys_clk        = 1'b0;
  logic         reset          = 1'b1;
  logic [7:0]   avs_address    = 8'h00;
  logic         avs_read       = 1'b0;
  logic         avs_write      = 1'b0;
  logic [31:0]  avs_writedata  = 32'h0000_0000;
  logic [3:0]   avs_byteenable = 4'h3;
  logic [31:0]  avs_readdata;
  logic         avs_waitrequest;
  iqps_sample_t c_sample       = 16'h0000;
  iqps_sample_t d_sample       = 16'h0000;
  iqps_sample_t c_corrected;
  iqps_sample_t d_delayed;
  iqps_word_t   cd_gain_active;
  iqps_word_t   cd_offset_active;
  iqps_coeff_t  cd_coeff_active;
  iqps_freq_t   ab_freq_active;
  iqps_word_t   ab_shift_active;
  iqps_word_t   ab_lut_index;
  int           err_count      = 0;
  int           tests_run      = 0;
  int           cyc            = 0;

  iqps_sync_regs DUT (
    .sys_clk          (sys_clk),
    .reset            (reset),
    .avs_address      (avs_address),
    .avs_read         (avs_read),
    .avs_write        (avs_write),
    .avs_writedata    (avs_writedata),
    .avs_byteenable   (avs_byteenable),
    .avs_readdata     (avs_readdata),
    .avs_waitrequest  (avs_waitrequest),
    .c_sample         (c_sample),
    .d_sample         (d_sample),
    .c_corrected      (c_corrected),
    .d_delayed        (d_delayed),
    .cd_gain_active   (cd_gain_active),
    .cd_offset_active (cd_offset_active),
    .cd_coeff_active  (cd_coeff_active),
    .ab_freq_active   (ab_freq_active),
    .ab_shift_active  (ab_shift_active),
    .ab_lut_index     (ab_lut_index)
  );

  // ---------------
  // Bus and helpers
  // ---------------
  initial forever #25 sys_clk = ~sys_clk;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Hang guard, far above the roughly 110 cycles needed
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      tally_and_finish;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] i, input logic [15:0] d, input logic [3:0] be = 4'h3);
    @(posedge sys_clk);
    avs_address <= {i, 2'b00};
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= be;
    avs_write <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest);
    avs_write <= 1'b0;
  endtask
  task automatic rdchk(input logic [5:0] i, input logic [31:0] exp);
    @(posedge sys_clk);
    avs_address <= {i, 2'b00};
    avs_read <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest);
    chk(avs_readdata, exp);
    avs_read <= 1'b0;
  endtask
  task automatic do_reset;
    reset <= 1'b1;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
  endtask
  task automatic settle;
    repeat (3) @(posedge sys_clk);
  endtask

  // ---------
  // Scenarios
  // ---------
  task automatic t_regs;
    rdchk(6'h11, 32'h0);
    rdchk(6'h12, 32'h0);
    rdchk(6'h3f, 32'h0);
    wr(6'h11, 16'hffff);
    rdchk(6'h11, 32'h0fff);
    settle;
    chk(cd_coeff_active, 32'h0);
    wr(6'h20, 16'h0001);
    settle;
    chk({20'h0, cd_coeff_active}, 32'h0000_0fff);
  endtask
  task automatic t_qmc;
    logic [2:0] x;
    wr(6'h0e, 16'h5678);
    wr(6'h0f, 16'h1234);
    settle;
    chk({cd_gain_active, cd_offset_active}, 32'h0);
    wr(6'h1e, 16'h0001);
    wr(6'h11, 16'h0800);
    // Never a mix of old and new
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      x = {cd_gain_active === 16'h1234, cd_offset_active === 16'h5678, cd_coeff_active === 12'h800};
      chk(32'(x == 3'b000 || x == 3'b111), 32'h1);
    end
    chk({cd_gain_active, cd_offset_active}, 32'h1234_5678);
    chk({20'h0, cd_coeff_active}, 32'h0000_0800);
  endtask
  task automatic t_dp;
    c_sample <= 16'h1000;
    d_sample <= 16'h0200;
    repeat (3) @(posedge sys_clk);
    chk({16'h0, c_corrected}, 32'h0f00);
    chk({16'h0, d_delayed}, 32'h0200);
  endtask
  task automatic t_mix;
    logic [15:0] a;
    wr(6'h12, 16'h4000);
    settle;
    chk(ab_shift_active, 32'h0);
    wr(6'h20, 16'h0002);
    settle;
    chk(ab_lut_index, 32'h4000);
    wr(6'h14, 16'h0000);
    wr(6'h15, 16'h0100);
    wr(6'h1f, 16'h0001);
    wr(6'h12, 16'h2000, 4'h0);
    settle;
    chk(ab_freq_active, 32'h0000_0000);
    chk(ab_shift_active, 32'h4000);
    wr(6'h12, 16'h6000);
    settle;
    chk(ab_freq_active, 32'h0100_0000);
    chk(ab_shift_active, 32'h6000);
    a = ab_lut_index;
    @(posedge sys_clk);
    chk(16'(ab_lut_index - a), 32'h0100);
  endtask

  initial begin
    do_reset;
    t_regs;
    t_qmc;
    t_dp;
    t_mix;
    do_reset;
    rdchk(6'h11, 32'h0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
